// [bpsf_regs.svh]
// constants of the battery process data framer
`ifndef BPSF_REGS_SVH
`define BPSF_REGS_SVH
`define BPSF_CLK_HZ          20000000
`define BPSF_PERIOD_1S_MS    1000
`define BPSF_PERIOD_4_MS     100
`define BPSF_PERIOD_8_MS     200
`define BPSF_TICK_1MS        (`BPSF_CLK_HZ / 1000)
`define BPSF_ID_MOD1         11'h181
`define BPSF_ID_MOD2         11'h281
`define BPSF_ID_MOD3         11'h381
`define BPSF_ID_MOD4         11'h481
`define BPSF_ID_SYS1         11'h19b
`define BPSF_ID_SYS2         11'h29b
`define BPSF_ID_SYS3         11'h39b
`define BPSF_ID_SYS4         11'h49b
`define BPSF_BIT_RATE        250000
`define BPSF_INFO_EMPTY      0
`define BPSF_INFO_ALMOST     1
`define BPSF_INFO_CHG_SW     2
`define BPSF_INFO_DSG_SW     3
`define BPSF_INFO_BYPASS     4
`define BPSF_INFO_FULL       6
`define BPSF_INFO_USED       16'h005f
`define BPSF_WARN_USED       16'hd89f
`define BPSF_WARN_OR_MASK    16'hfff8
`define BPSF_ERR_USED        16'hffff
`define BPSF_CC_USED         16'hfdf3
`endif

// [bpsf_pkg.sv]
// types of the battery process data framer
package bpsf_pkg;
    typedef struct packed {
        logic [10:0] id;     // identifier
        logic [3:0]  len;    // byte count
        logic [63:0] data;   // byte 0 in bits 63:56
    } bpsf_frame_type;
    typedef struct packed {
        logic [31:0] voltage_mv;
        logic [31:0] current_ma;
        logic [15:0] switch_temp;
        logic [15:0] cell_temp;
        logic [15:0] chg_volt_req;
        logic [15:0] chg_curr_req;
        logic [15:0] design_cap;
        logic [15:0] full_cap;
        logic [15:0] rem_cap;
        logic [15:0] info;
        logic [15:0] warn;
        logic [15:0] err;
        logic [15:0] chg_ctrl;
    } bpsf_module_type;
    typedef struct packed {
        logic [31:0] max_voltage_mv;
        logic [31:0] sum_current_ma;
        logic [15:0] switch_temp;
        logic [15:0] cell_temp;
        logic [31:0] design_cap;
        logic [31:0] full_cap;
        logic [31:0] rem_cap;
        logic [2:0]  warn_low;   // reserve, low charge, low voltage
    } bpsf_system_type;
endpackage

// [bpsf_fifo.sv]
// small frame fifo with valid/ready on both sides
`timescale 1ns/1ns
module bpsf_fifo #(
    parameter int WIDTH = 79,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,      // system clock
    input  wire logic             rst_n,    // async reset, low
    input  wire logic             in_valid, // write request
    output logic                  in_ready, // room left
    input  wire logic [WIDTH-1:0] in_data,  // write word
    output logic                  out_valid,// word present
    input  wire logic             out_ready,// reader takes word
    output logic [WIDTH-1:0]      out_data  // head word
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;  // write pointer
        logic [AW-1:0] rp;  // read pointer
        logic [AW:0]   cnt; // fill count
    } bpsf_fifo_state_type;
    bpsf_fifo_state_type st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic wr, rd;
    assign in_ready  = st.cnt != (AW+1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data  = mem[st.rp];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;
    // pointer update
    always_comb begin
        next_st = st;
        if (wr) next_st.wp = st.wp + 1'b1;
        if (rd) next_st.rp = st.rp + 1'b1;
        next_st.cnt = st.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) st <= '0;
        else        st <= next_st;
    end
    // storage write, no reset needed
    always_ff @(posedge clk) begin
        if (wr) mem[st.wp] <= in_data;
    end
endmodule

// [bpsf_framer.sv]
// battery process data framer: schedules, packs and queues cyclic frames
`timescale 1ns/1ns
// Function
// RULE1: module identifiers offset by node number minus one
// RULE2: frame one each second: voltage, current
// RULE3: frame two each second: temperatures, requests
// RULE4: frame three each second: three capacities, spare
// RULE5: frame four each 100 ms: status words
// RULE6: master: max voltage, summed current each second
// RULE7: master: temperatures and design capacity each second
// RULE8: master: full and remaining capacity each second
// RULE9: master: summary status frame every 200 ms
// RULE10: info bits 6,2,3,4 full and switches
// RULE11: info bits 0,1 empty, almost; rest zero
// RULE12: error bits 8 to 14 alarms
// RULE13: error bits 7 to 2 faults
// RULE14: error bits 1,0 locks, 15 unknown
// RULE15: warning bits 14,12,11,7,4,3 meanings
// RULE16: charge control bits 15,14,13
// RULE17: charge control bits 12,11,10
// RULE18: charge control bits 6,7,8 temperature range
// RULE19: charge control bits 4,5,0,1 enables
// RULE20: system info is AND over modules
// RULE21: system warning OR high, low computed
// RULE22: system error is OR over modules
// RULE23: system charge control is OR over modules
// RULE24: service requests answered by master elsewhere
// RULE25: bus fixed at 250 kbit/s
// RULE26: fields packed low byte first
`include "bpsf_regs.svh"
module bpsf_framer #(
    parameter int MODULES   = 4,                  // modules seen by the master
    parameter int TICK_CYC  = `BPSF_TICK_1MS,     // cycles per millisecond
    parameter int FIFO_DEPTH = 4                  // frame queue depth
) (
    input  wire logic                      clk,          // 20 MHz clock
    input  wire logic                      rst_n,        // async reset, low
    input  wire logic [6:0]                node_id,      // own node number, 1..
    input  wire logic                      is_master,    // module acts as master
    input  wire bpsf_pkg::bpsf_module_type own,          // own measurements
    input  wire logic [MODULES*16-1:0]     all_info,     // info words of modules
    input  wire logic [MODULES*16-1:0]     all_warn,     // warning words
    input  wire logic [MODULES*16-1:0]     all_err,      // error words
    input  wire logic [MODULES*16-1:0]     all_cc,       // charge control words
    input  wire bpsf_pkg::bpsf_system_type sys,          // system figures
    output bpsf_pkg::bpsf_frame_type       frame,        // frame to controller
    output logic                           frame_valid,  // frame present
    input  wire logic                      frame_ready,  // controller takes it
    output logic [15:0]                    module_information_flags, // own info
    output logic [15:0]                    module_warning_flags,     // own warn
    output logic [15:0]                    module_error_flags,       // own error
    output logic [15:0]                    charging_control_flags,   // own cc
    output logic [17:0]                    bit_rate      // fixed bit rate
);
    localparam int NSLOT = 8;
    typedef struct packed {
        logic [$clog2(TICK_CYC+1)-1:0] pre;    // cycles inside a millisecond
        logic [9:0]                    ms;     // ms inside a second
        logic [NSLOT-1:0]              pend;   // frames owed
        logic [2:0]                    slot;   // next slot to try
    } bpsf_state_type;
    bpsf_state_type st, next_st;
    bpsf_pkg::bpsf_frame_type cand;   // frame for current slot
    logic [15:0] sys_info, sys_warn, sys_err, sys_cc;
    logic        push, fifo_ready;
    logic        tick, sec, t100, t200;

    // low byte first in listed order
    function automatic logic [31:0] le32(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    function automatic logic [15:0] le16(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction
    // four 16-bit fields at bytes 0..7 of the data word
    function automatic logic [63:0] pack4(input logic [15:0] a, b, c, d);
        return {le16(a), le16(b), le16(c), le16(d)};
    endfunction
    // per-module identifier from node one base
    function automatic logic [10:0] mod_id(input logic [10:0] base, input logic [6:0] n);
        return base + {4'h0, n} - 11'h001;
    endfunction

    // documented fields only; undefined bits read zero
    assign module_information_flags = own.info & `BPSF_INFO_USED;  // [RULE10] [RULE11]
    assign module_warning_flags     = own.warn & `BPSF_WARN_USED;  // [RULE15]
    assign module_error_flags       = own.err  & `BPSF_ERR_USED;   // [RULE12] [RULE13] [RULE14]
    assign charging_control_flags   = own.chg_ctrl & `BPSF_CC_USED; // [RULE16] [RULE17] [RULE18] [RULE19]
    assign bit_rate = 18'(`BPSF_BIT_RATE);  // no rate setting exists [RULE25]

    // system status combination across modules
    always_comb begin
        sys_info = 16'hffff;
        sys_warn = 16'h0000;
        sys_err  = 16'h0000;
        sys_cc   = 16'h0000;
        for (int i = 0; i < MODULES; i++) begin
            sys_info &= all_info[i*16 +: 16];   // [RULE20]
            sys_warn |= all_warn[i*16 +: 16];   // [RULE21]
            sys_err  |= all_err[i*16 +: 16];    // [RULE22]
            sys_cc   |= all_cc[i*16 +: 16];     // [RULE23]
        end
        sys_info &= `BPSF_INFO_USED;
        sys_warn = (sys_warn & `BPSF_WARN_OR_MASK & `BPSF_WARN_USED)
                   | {13'h0000, sys.warn_low};  // master computes low bits [RULE21]
    end

    // period strobes
    assign tick = st.pre == ($bits(st.pre))'(TICK_CYC - 1);
    assign sec  = tick && st.ms == 10'(`BPSF_PERIOD_1S_MS - 1);
    assign t100 = tick && (st.ms % 10'(`BPSF_PERIOD_4_MS)) == 10'(`BPSF_PERIOD_4_MS - 1);
    assign t200 = tick && (st.ms % 10'(`BPSF_PERIOD_8_MS)) == 10'(`BPSF_PERIOD_8_MS - 1);

    // frame built for the slot under consideration
    always_comb begin
        cand.len = 4'h8;
        case (st.slot)
            3'd0: begin  // [RULE1] [RULE2] [RULE26]
                cand.id   = mod_id(`BPSF_ID_MOD1, node_id);
                cand.data = {le32(own.voltage_mv), le32(own.current_ma)};
            end
            3'd1: begin  // [RULE1] [RULE3]
                cand.id   = mod_id(`BPSF_ID_MOD2, node_id);
                cand.data = pack4(own.switch_temp, own.cell_temp,
                                  own.chg_volt_req, own.chg_curr_req);
            end
            3'd2: begin  // spare field sent as zero [RULE1] [RULE4]
                cand.id   = mod_id(`BPSF_ID_MOD3, node_id);
                cand.data = pack4(own.design_cap, own.full_cap, own.rem_cap, 16'h0000);
            end
            3'd3: begin  // [RULE1] [RULE5]
                cand.id   = mod_id(`BPSF_ID_MOD4, node_id);
                cand.data = pack4(module_information_flags, module_warning_flags,
                                  module_error_flags, charging_control_flags);
            end
            3'd4: begin  // [RULE6]
                cand.id   = `BPSF_ID_SYS1;
                cand.data = {le32(sys.max_voltage_mv), le32(sys.sum_current_ma)};
            end
            3'd5: begin  // [RULE7]
                cand.id   = `BPSF_ID_SYS2;
                cand.data = {le16(sys.switch_temp), le16(sys.cell_temp), le32(sys.design_cap)};
            end
            3'd6: begin  // [RULE8]
                cand.id   = `BPSF_ID_SYS3;
                cand.data = {le32(sys.full_cap), le32(sys.rem_cap)};
            end
            3'd7: begin  // [RULE9]
                cand.id   = `BPSF_ID_SYS4;
                cand.data = pack4(sys_info, sys_warn, sys_err, sys_cc);
            end
            default: begin
                cand.id   = 11'h000;
                cand.data = 64'h0;
            end
        endcase
    end

    assign push = st.pend[st.slot];

    // timers, pending flags and slot scan
    always_comb begin
        next_st = st;
        next_st.pre = tick ? '0 : st.pre + 1'b1;
        if (tick) next_st.ms = sec ? 10'h000 : st.ms + 10'h001;
        // leave slot once served or if nothing owed
        if (!push || fifo_ready) begin
            if (push) next_st.pend[st.slot] = 1'b0;
            next_st.slot = st.slot + 3'd1;
        end
        // new periods set pending; set wins over the clear above
        if (sec)  next_st.pend[2:0] = 3'b111;                    // [RULE2] [RULE3] [RULE4]
        if (t100) next_st.pend[3] = 1'b1;                        // [RULE5]
        if (sec && is_master)  next_st.pend[6:4] = 3'b111;       // [RULE6] [RULE7] [RULE8]
        if (t200 && is_master) next_st.pend[7] = 1'b1;           // [RULE9]
        if (!is_master) next_st.pend[7:4] = 4'h0;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) st <= '0;
        else        st <= next_st;
    end

    // outgoing frame queue with back-pressure from the controller
    bpsf_fifo #(
        .WIDTH ($bits(bpsf_pkg::bpsf_frame_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (cand),
        .out_valid (frame_valid),
        .out_ready (frame_ready),
        .out_data  (frame)
    );
endmodule

// [bpsf_framer_assertions.sv]
// port assertions of the battery process data framer
`timescale 1ns/1ns
module bpsf_framer_assertions #(
    parameter int MODULES = 4                            // modules seen by master
) (
    input wire logic                      clk,           // system clock
    input wire logic                      rst_n,         // async reset, low
    input wire logic [6:0]                node_id,       // own node number
    input wire logic                      is_master,     // master role
    input wire bpsf_pkg::bpsf_module_type own,           // own values
    input wire logic [MODULES*16-1:0]     all_err,       // error words
    input wire bpsf_pkg::bpsf_frame_type  frame,         // head frame
    input wire logic                      frame_valid,   // frame present
    input wire logic                      frame_ready,   // frame taken
    input wire logic [15:0]               module_information_flags, // info
    input wire logic [15:0]               module_warning_flags,     // warn
    input wire logic [15:0]               module_error_flags,       // error
    input wire logic [15:0]               charging_control_flags,   // cc
    input wire logic [17:0]               bit_rate       // bit rate
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] or_err;  // error words ored over modules
    // system error word as the master must form it
    always_comb begin
        or_err = 16'h0000;
        for (int i = 0; i < MODULES; i++) begin
            or_err = or_err | all_err[16*i +: 16];
        end
    end
    property p_info; module_information_flags == (own.info & 16'h005f); endproperty
    a_info: assert property (p_info) else $error("info flags wrong");
    property p_warn; module_warning_flags == (own.warn & 16'hd89f); endproperty
    a_warn: assert property (p_warn) else $error("warning flags wrong");
    property p_err; module_error_flags == own.err; endproperty
    a_err: assert property (p_err) else $error("error flags wrong");
    property p_cc; charging_control_flags == (own.chg_ctrl & 16'hfdf3); endproperty
    a_cc: assert property (p_cc) else $error("charge control flags wrong");
    property p_rate; bit_rate == 18'h3d090; endproperty
    a_rate: assert property (p_rate) else $error("bit rate wrong");
    property p_hold; frame_valid && !frame_ready |=> frame_valid && $stable(frame); endproperty
    a_hold: assert property (p_hold) else $error("frame dropped before taken");
    property p_len; frame_valid |-> frame.len == 4'h8; endproperty
    a_len: assert property (p_len) else $error("frame length wrong");
    property p_id; frame_valid |-> (frame.id[6:0] == node_id || is_master
        && frame.id[6:0] == 7'h1b) && frame.id[10:7] inside {4'h3, 4'h5, 4'h7, 4'h9}; endproperty
    a_id: assert property (p_id) else $error("frame identifier wrong");
    property p_sys_err; frame_valid && frame.id == 11'h49b
        |-> frame.data[31:16] == {or_err[7:0], or_err[15:8]}; endproperty
    a_sys_err: assert property (p_sys_err) else $error("system error word wrong");
endmodule
bind bpsf_framer bpsf_framer_assertions #(.MODULES(MODULES)) i_chk (.clk(clk), .rst_n(rst_n),
    .node_id(node_id), .is_master(is_master), .own(own), .all_err(all_err), .frame(frame),
    .frame_valid(frame_valid), .frame_ready(frame_ready),
    .module_information_flags(module_information_flags),
    .module_warning_flags(module_warning_flags), .module_error_flags(module_error_flags),
    .charging_control_flags(charging_control_flags), .bit_rate(bit_rate));

// [bpsf_ctrl_model.sv]
// bus controller model: takes frames from the framer and logs them
`timescale 1ns/1ns
module bpsf_ctrl_model (
    input  wire logic                     clk,          // system clock
    input  wire logic                     rst_n,        // async reset, low
    input  wire logic                     slow,         // ready one cycle in four
    input  wire bpsf_pkg::bpsf_frame_type frame,        // head frame
    input  wire logic                     frame_valid,  // frame present
    output logic                          frame_ready   // frame taken
);
    bpsf_pkg::bpsf_frame_type log_q[$];  // frames taken, in order
    logic [1:0]               pace;      // stall counter
    // log at each meeting of valid and ready, then pace the next ready
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            log_q.delete();
            pace        <= 2'h0;
            frame_ready <= 1'b0;
        end else begin
            if (frame_valid && frame_ready) log_q.push_back(frame);
            pace        <= pace + 2'h1;
            frame_ready <= !slow || (pace == 2'h3);
        end
    end
endmodule

// [battery_pdo_status_framer_tb.sv]
// testbench of the battery process data framer
`timescale 1ns/1ns
module battery_pdo_status_framer_tb;
    logic                      clk, rst_n, is_master, slow, frame_valid, frame_ready;
    logic [6:0]                node_id;       // own node number
    bpsf_pkg::bpsf_module_type own;           // own values
    bpsf_pkg::bpsf_system_type sys;           // system figures
    bpsf_pkg::bpsf_frame_type  frame;         // head frame
    logic [31:0]               all_info, all_warn, all_err, all_cc; // two modules
    logic [15:0]               f_info, f_warn, f_err, f_cc;         // flag outputs
    logic [17:0]               bit_rate;      // fixed rate
    int                        error_cnt, check_count;
    bpsf_framer #(.MODULES(2), .TICK_CYC(4), .FIFO_DEPTH(4)) i_dut (.clk(clk), .rst_n(rst_n),
        .node_id(node_id), .is_master(is_master), .own(own), .all_info(all_info),
        .all_warn(all_warn), .all_err(all_err), .all_cc(all_cc), .sys(sys), .frame(frame),
        .frame_valid(frame_valid), .frame_ready(frame_ready), .module_information_flags(f_info),
        .module_warning_flags(f_warn), .module_error_flags(f_err),
        .charging_control_flags(f_cc), .bit_rate(bit_rate));
    bpsf_ctrl_model i_ctrl (.clk(clk), .rst_n(rst_n), .slow(slow), .frame(frame),
        .frame_valid(frame_valid), .frame_ready(frame_ready));
    // clock of 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [15:0] l16(input logic [15:0] x);
        return {x[7:0], x[15:8]};
    endfunction
    function automatic logic [31:0] l32(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction
    // expected identifier of slot k
    function automatic logic [10:0] exp_id(input int k, input logic [6:0] node);
        if (k < 4) return 11'h181 + 11'(k * 256) + 11'(node - 7'h01);
        return 11'h19b + 11'((k - 4) * 256);
    endfunction
    // expected payload of slot k, low byte first
    function automatic logic [63:0] exp_data(input int k);
        case (k)
            0: return {l32(own.voltage_mv), l32(own.current_ma)};
            1: return {l16(own.switch_temp), l16(own.cell_temp), l16(own.chg_volt_req),
                       l16(own.chg_curr_req)};
            2: return {l16(own.design_cap), l16(own.full_cap), l16(own.rem_cap), 16'h0000};
            3: return {l16(own.info), l16(own.warn), l16(own.err), l16(own.chg_ctrl)};
            4: return {l32(sys.max_voltage_mv), l32(sys.sum_current_ma)};
            5: return {l16(sys.switch_temp), l16(sys.cell_temp), l32(sys.design_cap)};
            6: return {l32(sys.full_cap), l32(sys.rem_cap)};
            default: return {l16(16'h0044), l16(16'h488d), l16(16'h8301), l16(16'hc051)};
        endcase
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // reset for three cycles with a new role
    task automatic start(input logic [6:0] node, input logic master, input logic pace);
        @(negedge clk);
        rst_n = 1'b0;
        node_id = node;
        is_master = master;
        slow = pace;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic wait_frames(input int n);
        int i;
        for (i = 0; i < 9000 && i_ctrl.log_q.size() < n; i++) @(negedge clk);
        if (i == 9000) begin
            error_cnt++;
            $display("BAD %0t frames missing", $time);
            conclude();
        end
    endtask
    // plain module: four own frames, no system frames
    task automatic run_slave();
        start(7'h01, 1'b0, 1'b0);
        wait_frames(13);
        repeat (300) @(negedge clk);
        check(64'(i_ctrl.log_q.size()), 64'd13);
        for (int k = 0; k < 4; k++) begin
            check(64'(i_ctrl.log_q[9+k].id), 64'(exp_id(k, 7'h01)));
            check(i_ctrl.log_q[9+k].data, exp_data(k));
        end
    endtask
    // master node four, slow controller fills the queue
    task automatic run_master();
        int n184, n484, n49b;  // frames per kind in the second period
        start(7'h04, 1'b1, 1'b1);
        wait_frames(42);
        repeat (300) @(negedge clk);
        check(64'(i_ctrl.log_q.size()), 64'd42);
        check(64'(i_ctrl.log_q[0].id), 64'h484);
        check(64'(i_ctrl.log_q[2].id), 64'h49b);
        // stalls move the slot scan, so the second period is counted by kind
        n184 = 0;
        n484 = 0;
        n49b = 0;
        for (int k = 21; k < 42; k++) begin
            if (i_ctrl.log_q[k].id == 11'h184) n184++;
            if (i_ctrl.log_q[k].id == 11'h484) n484++;
            if (i_ctrl.log_q[k].id == 11'h49b) n49b++;
        end
        check(64'(n184), 64'd1);
        check(64'(n484), 64'd10);
        check(64'(n49b), 64'd5);
        for (int k = 0; k < 8; k++) begin
            check(64'(i_ctrl.log_q[13+k].id), 64'(exp_id(k, 7'h04)));
            check(i_ctrl.log_q[13+k].data, exp_data(k));
        end
    endtask
    // undocumented status bits read back as zero
    task automatic run_flags();
        @(negedge clk);
        own.info = 16'hffff;
        own.warn = 16'hffff;
        own.err = 16'hffff;
        own.chg_ctrl = 16'hffff;
        @(posedge clk);
        check(64'(f_info), 64'h005f);
        check(64'(f_warn), 64'hd89f);
        check(64'(f_err), 64'hffff);
        check(64'(f_cc), 64'hfdf3);
        check(64'(bit_rate), 64'd250000);
    endtask
    initial begin
        error_cnt = 0;
        check_count = 0;
        rst_n = 1'b0;
        node_id = 7'h01;
        is_master = 1'b0;
        slow = 1'b0;
        own = '{32'h0001d4c0, 32'hfffffc18, 16'h00fa, 16'h0104, 16'h6d60, 16'h2710,
               16'h4e20, 16'h4a38, 16'h2710, 16'h004c, 16'h1898, 16'hc3a5, 16'hd4f1};
        sys = '{32'h0001d4c0, 32'hfffff830, 16'h00fa, 16'h0110, 32'h00013880,
               32'h00012110, 32'h0000c350, 3'h5};
        all_info = {16'h0045, 16'h004c};
        all_warn = {16'h4008, 16'h0880};
        all_err = {16'h8001, 16'h0300};
        all_cc = {16'h0011, 16'hc040};
        run_slave();
        run_master();
        run_flags();
        conclude();
    end
endmodule
